// >>> hw/afrc_defs.vh
`ifndef AFRC_DEFS_VH
`define AFRC_DEFS_VH

// register byte addresses
`define AFRC_ADDR_STATUS      5'h00
`define AFRC_ADDR_CHSEL       5'h04
`define AFRC_ADDR_MODE        5'h08
`define AFRC_ADDR_FIFOCTL     5'h0c
`define AFRC_ADDR_RES_HIGH    5'h10
`define AFRC_ADDR_RES_LOW     5'h14

// fifo_scan_control fields
`define AFRC_FC_SCAN_BIT      6
`define AFRC_FC_COMB_BIT      5
`define AFRC_FC_DEP_HI        2
`define AFRC_FC_DEP_LO        0
`define AFRC_FC_WMASK         8'h67

// conversion_control fields (continuous, resolution mode)
`define AFRC_MODE_CONT_BIT    4
`define AFRC_MODE_RES_HI      3
`define AFRC_MODE_RES_LO      2

// status fields
`define AFRC_ST_CONVERSION_COMPLETE_FLAG_BIT      7
`define AFRC_ST_FULL_BIT      2

// resolution mode codes
`define AFRC_RES_8BIT         2'h0
`define AFRC_RES_10BIT        2'h1
`define AFRC_RES_12BIT        2'h2

`define AFRC_DEP_OFF          3'h0
`define AFRC_DEP_BASE         3'h1

// axi response codes
`define AFRC_RESP_OKAY        2'h0
`define AFRC_RESP_SLVERR      2'h2

`endif

// >>> hw/afrc_fifo.v
`default_nettype none
// small circular queue; writing while full drops the oldest entry
module afrc_fifo #(
	parameter W = 8,
	parameter D = 8,
	parameter AW = 3
) (
	input  wire          sys_clk,   // bus clock
	input  wire          rst_b,     // sync reset, low
	input  wire          flush,     // empty the queue
	input  wire [AW:0]   lim,       // active depth, 1..D
	input  wire          push,      // write strobe
	input  wire [W-1:0]  din,       // write data
	input  wire          pop,       // read strobe
	output wire [W-1:0]  dout,      // head entry
	output wire [AW:0]   count,     // entries held
	output wire          full       // count reached lim
);
	reg [W-1:0]  mem [0:D-1];
	reg [AW-1:0] rd;
	reg [AW:0]   cnt;
	wire [AW-1:0] wr;
	wire do_pop;

	function [AW-1:0] wrap;
		input [AW:0] v;
		begin
			if (v >= D[AW:0])
				wrap = v[AW-1:0] - D[AW-1:0];
			else
				wrap = v[AW-1:0];
		end
	endfunction

	assign full   = (cnt >= lim);
	assign count  = cnt;
	assign dout   = mem[rd];
	assign wr     = wrap({1'b0, rd} + cnt);
	// overwrite on full advances the head to keep the newest data
	assign do_pop = (pop && cnt != 0) || (push && full);

	always @(posedge sys_clk) begin
		if (push)
			mem[wr] <= din;
	end

	always @(posedge sys_clk) begin
		if (!rst_b || flush) begin
			rd  <= {AW{1'b0}};
			cnt <= {(AW+1){1'b0}};
		end else begin
			if (do_pop)
				rd <= wrap({1'b0, rd} + 1'b1);
			if (push && !do_pop)
				cnt <= cnt + 1'b1;
			else if (!push && do_pop)
				cnt <= cnt - 1'b1;
		end
	end
endmodule
`default_nettype wire

// >>> hw/afrc_top.v
`include "afrc_defs.vh"
`default_nettype none
module afrc_top #(
	parameter CH_W  = 5,
	parameter DEPTH = 5,
	parameter AW    = 3
) (
	input  wire              sys_clk,        // bus clock
	input  wire              rst_b,          // sync reset, low
	input  wire [4:0]        s_axi_awaddr,   // write address
	input  wire              s_axi_awvalid,  // write address valid
	output wire              s_axi_awready,  // write address ready
	input  wire [31:0]       s_axi_wdata,    // write data
	input  wire [3:0]        s_axi_wstrb,    // byte enables
	input  wire              s_axi_wvalid,   // write data valid
	output wire              s_axi_wready,   // write data ready
	output reg  [1:0]        s_axi_bresp,    // write response
	output reg               s_axi_bvalid,   // write response valid
	input  wire              s_axi_bready,   // write response ready
	input  wire [4:0]        s_axi_araddr,   // read address
	input  wire              s_axi_arvalid,  // read address valid
	output wire              s_axi_arready,  // read address ready
	output reg  [31:0]       s_axi_rdata,    // read data
	output reg  [1:0]        s_axi_rresp,    // read response
	output reg               s_axi_rvalid,   // read data valid
	input  wire              s_axi_rready,   // read data ready
	output wire              conv_start,     // start pulse to converter
	output wire [CH_W-1:0]   conv_channel,   // channel to convert
	output wire [1:0]        conv_res_mode,  // resolution mode
	input  wire              conv_done,      // conversion end pulse
	input  wire [15:0]       conv_result,    // converted value
	input  wire              cmp_enable,     // automatic compare on
	input  wire              cmp_hit         // compare met, with done
);
	localparam ST_IDLE = 3'b001;
	localparam ST_CONV = 3'b010;
	localparam ST_WAIT = 3'b100;

	reg  [7:0]      fifo_scan_control;
	reg  [7:0]      conv_ctl;
	reg  [CH_W-1:0] chan_reg;
	reg  [15:0]     res_reg;
	reg             res_valid;
	reg             rd_lock;
	reg             conversion_complete_flag;
	reg             any_hit;
	reg             all_hit;
	reg             set_running;
	reg  [2:0]      state;
	reg  [2:0]      next_state;
	reg  [4:0]      wa;
	reg             wa_held;
	reg  [31:0]     wd;
	reg  [3:0]      ws;
	reg             wd_held;

	wire [2:0]      dep_code = fifo_scan_control[`AFRC_FC_DEP_HI:`AFRC_FC_DEP_LO];
	wire            fifo_on  = (dep_code != `AFRC_DEP_OFF);
	wire            scan_on  = fifo_scan_control[`AFRC_FC_SCAN_BIT];
	wire            comb_and = fifo_scan_control[`AFRC_FC_COMB_BIT];
	wire            cont_on  = conv_ctl[`AFRC_MODE_CONT_BIT];
	wire [1:0]      res_mode = conv_ctl[`AFRC_MODE_RES_HI:`AFRC_MODE_RES_LO];
	wire            mode_12  = (res_mode == `AFRC_RES_12BIT);

	// depth code n selects n+1 levels, clamped to the built depth
	function [AW:0] dep_levels;
		input [2:0] c;
		reg   [AW:0] v;
		begin
			v = {{(AW-2){1'b0}}, c} + {{AW{1'b0}}, 1'b1};
			dep_levels = (v > DEPTH[AW:0]) ? DEPTH[AW:0] : v;
		end
	endfunction

	function [31:0] merge;
		input [31:0] old;
		input [31:0] data;
		input [3:0]  strb;
		integer i;
		begin
			merge = old;
			for (i = 0; i < 4; i = i + 1)
				if (strb[i])
					merge[i*8 +: 8] = data[i*8 +: 8];
		end
	endfunction

	wire [AW:0] lim = dep_levels(dep_code);

	// ---------------- axi4-lite write side ----------------
	wire w_go = wa_held && wd_held && !s_axi_bvalid;
	assign s_axi_awready = !wa_held && !s_axi_bvalid;
	assign s_axi_wready  = !wd_held && !s_axi_bvalid;

	wire wr_chsel = w_go && wa[4:2] == `AFRC_ADDR_CHSEL >> 2;
	wire wr_mode  = w_go && wa[4:2] == `AFRC_ADDR_MODE >> 2;
	wire wr_fifo  = w_go && wa[4:2] == `AFRC_ADDR_FIFOCTL >> 2;
	wire wr_known = wr_chsel || wr_mode || wr_fifo ||
		(w_go && wa[4:2] == `AFRC_ADDR_STATUS >> 2);
	wire [31:0] wd_mode = merge({24'h0, conv_ctl}, wd, ws);
	wire [31:0] wd_fifo = merge({24'h0, fifo_scan_control}, wd, ws);
	wire res_change = wr_mode &&
		(wd_mode[`AFRC_MODE_RES_HI:`AFRC_MODE_RES_LO] != res_mode);
	wire ch_push = wr_chsel && ws[0] && fifo_on;

	always @(posedge sys_clk) begin
		if (!rst_b) begin
			wa_held      <= 1'b0;
			wd_held      <= 1'b0;
			wa           <= 5'h00;
			wd           <= 32'h0;
			ws           <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= `AFRC_RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				wa_held <= 1'b1;
				wa      <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				wd_held <= 1'b1;
				wd      <= s_axi_wdata;
				ws      <= s_axi_wstrb;
			end
			if (w_go) begin
				wa_held      <= 1'b0;
				wd_held      <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_known ? `AFRC_RESP_OKAY : `AFRC_RESP_SLVERR;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// ---------------- control registers ----------------
	always @(posedge sys_clk) begin
		if (!rst_b) begin
			fifo_scan_control <= 8'h00;
			conv_ctl          <= 8'h00;
			chan_reg          <= {CH_W{1'b0}};
		end else begin
			if (wr_fifo)
				fifo_scan_control <= wd_fifo[7:0] & `AFRC_FC_WMASK;
			if (wr_mode)
				conv_ctl <= wd_mode[7:0];
			if (wr_chsel && ws[0])
				chan_reg <= wd[CH_W-1:0];
		end
	end

	// ---------------- channel and result queues ----------------
	wire [CH_W-1:0] ch_head;
	wire [AW:0]     ch_count;
	wire [15:0]     rf_head;
	wire [AW:0]     rf_count;
	wire            rf_full;
	wire            rf_push;
	wire            rf_pop;
	wire            ch_pop;
	wire            flush = !fifo_on || res_change;

	afrc_fifo #(.W(CH_W), .D(DEPTH), .AW(AW)) u_chan (
		.sys_clk (sys_clk),
		.rst_b   (rst_b),
		.flush   (!fifo_on),
		.lim     (lim),
		.push    (ch_push),
		.din     (wd[CH_W-1:0]),
		.pop     (ch_pop),
		.dout    (ch_head),
		.count   (ch_count),
		.full    ()
	);

	afrc_fifo #(.W(16), .D(DEPTH), .AW(AW)) u_res (
		.sys_clk (sys_clk),
		.rst_b   (rst_b),
		.flush   (flush),
		.lim     (lim),
		.push    (rf_push),
		.din     (conv_result),
		.pop     (rf_pop),
		.dout    (rf_head),
		.count   (rf_count),
		.full    (rf_full)
	);

	// ---------------- conversion sequencing ----------------
	wire ch_ready  = (ch_count >= lim);
	wire keep      = !cmp_enable || cmp_hit;
	wire set_start = fifo_on && state == ST_IDLE && ch_ready && !conversion_complete_flag;
	// in scan mode the head channel stays loaded for the whole set
	assign ch_pop  = fifo_on && !scan_on && state == ST_CONV &&
		conv_done && ch_count != 0;
	assign rf_push = fifo_on && state == ST_CONV && conv_done && keep;
	wire set_end   = fifo_on && state == ST_CONV && conv_done &&
		(scan_on ? (rf_full || (rf_push && rf_count + 1'b1 >= lim))
		: (ch_count <= 1));
	wire set_ok    = comb_and ? (all_hit && (!cmp_enable || cmp_hit))
		: (any_hit || keep);
	wire one_start = !fifo_on && state == ST_IDLE && wr_chsel && ws[0];

	always @* begin
		next_state = state;
		case (state)
		ST_IDLE: if (set_start)
			next_state = ST_CONV;
		else if (one_start)
			next_state = ST_WAIT;
		ST_CONV: if (conv_done) begin
			if (!fifo_on)
				next_state = cont_on ? ST_WAIT : ST_IDLE;
			else if (set_end)
				next_state = (scan_on && cont_on) ? ST_WAIT : ST_IDLE;
			// restart a cycle later so the popped head has advanced
			else
				next_state = ST_WAIT;
		end
		ST_WAIT: next_state = ST_CONV;
		default: next_state = ST_IDLE;
		endcase
	end
	assign conv_start   = (state == ST_IDLE && next_state == ST_CONV) ||
		state == ST_WAIT;
	assign conv_channel = fifo_on ? ch_head : chan_reg;
	assign conv_res_mode = res_mode;

	// ---------------- single result, interlock, flags ----------------
	wire rd_high = s_axi_arvalid && s_axi_arready &&
		s_axi_araddr[4:2] == `AFRC_ADDR_RES_HIGH >> 2;
	wire rd_low  = s_axi_arvalid && s_axi_arready &&
		s_axi_araddr[4:2] == `AFRC_ADDR_RES_LOW >> 2;
	wire rd_stat = s_axi_arvalid && s_axi_arready &&
		s_axi_araddr[4:2] == `AFRC_ADDR_STATUS >> 2;
	assign rf_pop = fifo_on && rd_low;

	always @(posedge sys_clk) begin
		if (!rst_b) begin
			state       <= ST_IDLE;
			res_reg     <= 16'h0000;
			res_valid   <= 1'b0;
			rd_lock     <= 1'b0;
			conversion_complete_flag        <= 1'b0;
			any_hit     <= 1'b0;
			all_hit     <= 1'b1;
			set_running <= 1'b0;
		end else begin
			state <= next_state;
			if (set_start) begin
				any_hit     <= 1'b0;
				all_hit     <= 1'b1;
				set_running <= 1'b1;
			end else if (fifo_on && state == ST_CONV && conv_done) begin
				any_hit <= any_hit || keep;
				all_hit <= all_hit && keep;
			end
			// a locked result is dropped, not queued
			if (!fifo_on && state == ST_CONV && conv_done && keep &&
				!rd_lock) begin
				res_reg   <= conv_result;
				res_valid <= 1'b1;
			end
			if (rd_high && mode_12 && !fifo_on)
				rd_lock <= 1'b1;
			else if (rd_low || !mode_12)
				rd_lock <= 1'b0;
			if (res_change) begin
				res_valid <= 1'b0;
				rd_lock   <= 1'b0;
			end
			// a completion in the same cycle as a clearing read wins
			if (state == ST_CONV && conv_done &&
				(fifo_on ? (set_end && set_ok) : keep))
				conversion_complete_flag <= 1'b1;
			else if (rd_low || rd_stat && 1'b0 || wr_chsel || !fifo_on &&
				1'b0)
				conversion_complete_flag <= 1'b0;
			if (set_end)
				set_running <= 1'b0;
		end
	end

	wire [15:0] res_view = fifo_on ? rf_head :
		(res_valid ? res_reg : 16'h0000);

	// ---------------- axi4-lite read side ----------------
	assign s_axi_arready = !s_axi_rvalid;
	reg [31:0] rd_mux;
	reg        rd_ok;
	always @* begin
		rd_ok  = 1'b1;
		rd_mux = 32'h0;
		case (s_axi_araddr[4:2])
		`AFRC_ADDR_STATUS >> 2: begin
			rd_mux[`AFRC_ST_CONVERSION_COMPLETE_FLAG_BIT] = conversion_complete_flag;
			rd_mux[`AFRC_ST_FULL_BIT] = rf_full && fifo_on;
		end
		`AFRC_ADDR_CHSEL >> 2:   rd_mux[CH_W-1:0] = conv_channel;
		`AFRC_ADDR_MODE >> 2:    rd_mux[7:0] = conv_ctl;
		`AFRC_ADDR_FIFOCTL >> 2:
			rd_mux[7:0] = fifo_scan_control & `AFRC_FC_WMASK;
		`AFRC_ADDR_RES_HIGH >> 2: rd_mux[7:0] = res_view[15:8];
		`AFRC_ADDR_RES_LOW >> 2:  rd_mux[7:0] = res_view[7:0];
		default: rd_ok = 1'b0;
		endcase
	end

	always @(posedge sys_clk) begin
		if (!rst_b) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0;
			s_axi_rresp  <= `AFRC_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= rd_mux;
			s_axi_rresp  <= rd_ok ? `AFRC_RESP_OKAY : `AFRC_RESP_SLVERR;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end
endmodule
`default_nettype wire

// >>> tb/afrc_top_props.sv
`include "afrc_defs.vh"
`default_nettype none
module afrc_props (
	input wire logic        sys_clk,        // bus clock
	input wire logic        rst_b,          // sync reset, low
	input wire logic        s_axi_awvalid,  // aw valid
	input wire logic        s_axi_awready,  // aw ready
	input wire logic        s_axi_wvalid,   // w valid
	input wire logic        s_axi_wready,   // w ready
	input wire logic [1:0]  s_axi_bresp,    // b response
	input wire logic        s_axi_bvalid,   // b valid
	input wire logic        s_axi_bready,   // b ready
	input wire logic [4:0]  s_axi_araddr,   // read address
	input wire logic        s_axi_arvalid,  // ar valid
	input wire logic        s_axi_arready,  // ar ready
	input wire logic [31:0] s_axi_rdata,    // read data
	input wire logic [1:0]  s_axi_rresp,    // r response
	input wire logic        s_axi_rvalid,   // r valid
	input wire logic        s_axi_rready,   // r ready
	input wire logic [1:0]  conv_res_mode   // resolution code
);
	timeunit 1ns;
	timeprecision 1ns;
	wire ar_go = s_axi_arvalid && s_axi_arready;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_b);
	a_b_answer: assert property (s_axi_awvalid && s_axi_awready &&
		s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
		else $error("write not answered");
	a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
		s_axi_bvalid && $stable(s_axi_bresp)) else $error("b dropped");
	a_r_answer: assert property (ar_go |=> s_axi_rvalid)
		else $error("read not answered");
	a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata)) else $error("r dropped");
	a_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken while busy");
	a_reset_quiet: assert property ($rose(rst_b) |->
		!s_axi_bvalid && !s_axi_rvalid) else $error("busy after reset");
	a_unmapped_err: assert property (ar_go && s_axi_araddr[4:2] > 3'h5 |=>
		s_axi_rresp == `AFRC_RESP_SLVERR && s_axi_rdata == 32'h0)
		else $error("unmapped read");
	a_fc_reserved: assert property (ar_go &&
		s_axi_araddr == `AFRC_ADDR_FIFOCTL |=> s_axi_rdata[31:7] == 0 &&
		s_axi_rdata[4:3] == 2'h0) else $error("reserved bits set");
	a_high_upper: assert property (ar_go &&
		s_axi_araddr == `AFRC_ADDR_RES_HIGH && conv_res_mode == 2'h2
		|=> s_axi_rdata[31:4] == 0) else $error("high byte too wide");
	a_low_width: assert property (ar_go &&
		s_axi_araddr == `AFRC_ADDR_RES_LOW |=> s_axi_rdata[31:8] == 0)
		else $error("low byte too wide");
endmodule
bind afrc_top afrc_props u_props (.sys_clk(sys_clk), .rst_b(rst_b),
	.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
	.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
	.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
	.s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
	.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
	.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
	.conv_res_mode(conv_res_mode));
`default_nettype wire

// >>> tb/afrc_top_tb.sv
`include "afrc_defs.vh"
`default_nettype none
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin n_fail++; \
	$display("CHECK FAILED %0t got %h exp %h", $time, g, e); end end
module afrc_top_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic        sys_clk, rst_b, awvalid, wvalid, bready, arvalid, rready;
	logic [4:0]  awaddr, araddr, ch_l;
	logic [31:0] wdata;
	logic        done, cmp_en, hit;
	logic [15:0] result;
	logic [2:0]  cd;
	wire         awready, wready, bvalid, arready, rvalid, start;
	wire  [1:0]  bresp, rresp, res_mode;
	wire  [31:0] rdata;
	wire  [4:0]  chan;
	int          n_fail, check_count, n_start, cyc;
	afrc_top u_dut (.sys_clk(sys_clk), .rst_b(rst_b),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready), .conv_start(start),
		.conv_channel(chan), .conv_res_mode(res_mode), .conv_done(done),
		.conv_result(result), .cmp_enable(cmp_en), .cmp_hit(hit));
	function automatic [7:0] hb(input [4:0] c);
		hb = {4'h0, 3'h5, c[4]};
	endfunction
	function automatic [7:0] lb(input [4:0] c);
		lb = {c[3:0], 4'ha};
	endfunction
	task automatic complete_run;
		$display("checks %0d failures %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// converter stand-in: result four cycles after start, odd channels hit
	always @(posedge sys_clk) begin
		done <= (cd == 3'h1);
		result <= {hb(ch_l), lb(ch_l)};
		hit <= ch_l[0];
		if (start) begin
			cd <= 3'h3;
			ch_l <= chan;
		end else if (cd != 3'h0)
			cd <= cd - 3'h1;
		n_start <= rst_b ? n_start + int'(start) : 0;
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_fail++;
			complete_run();
		end
	end
	initial begin
		sys_clk = 1'b0;
		forever #10 sys_clk = ~sys_clk;
	end
	task automatic wr(input [4:0] a, input [7:0] d);
		logic ad, wd;
		@(posedge sys_clk);
		awaddr <= a;
		wdata <= {24'h0, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		ad = 0;
		wd = 0;
		while (!(ad && wd)) begin
			@(posedge sys_clk);
			if (awvalid && awready) begin
				ad = 1;
				awvalid <= 1'b0;
			end
			if (wvalid && wready) begin
				wd = 1;
				wvalid <= 1'b0;
			end
		end
		while (bvalid !== 1'b1) @(posedge sys_clk);
		bready <= 1'b0;
	endtask
	task automatic rd(input [4:0] a, output [31:0] d, output [1:0] r);
		@(posedge sys_clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge sys_clk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		do @(posedge sys_clk); while (rvalid !== 1'b1);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask
	task automatic rc(input [4:0] a, input [7:0] e);
		logic [31:0] d;
		logic [1:0]  r;
		rd(a, d, r);
		`CHK(d, {24'h0, e})
	endtask
	task automatic do_rst;
		@(posedge sys_clk);
		rst_b <= 1'b0;
		repeat (5) @(posedge sys_clk);
		rst_b <= 1'b1;
	endtask
	// fixed wait is enough: the stand-in always finishes in four cycles
	task automatic cv(input [4:0] c);
		wr(`AFRC_ADDR_CHSEL, {3'h0, c});
		repeat (12) @(posedge sys_clk);
	endtask
	task automatic t_regs;
		logic [31:0] d;
		logic [1:0]  r;
		do_rst();
		rc(`AFRC_ADDR_FIFOCTL, 8'h00);
		rc(`AFRC_ADDR_STATUS, 8'h00);
		`CHK(n_start, 0)
		wr(`AFRC_ADDR_FIFOCTL, 8'hff);
		rc(`AFRC_ADDR_FIFOCTL, 8'h67);
		rd(5'h1c, d, r);
		`CHK(r, `AFRC_RESP_SLVERR)
	endtask
	task automatic t_nolock;
		logic [31:0] d;
		logic [1:0]  r;
		do_rst();
		cv(5'h05);
		`CHK(n_start, 1)
		rd(`AFRC_ADDR_RES_HIGH, d, r);
		cv(5'h06);
		rc(`AFRC_ADDR_RES_LOW, lb(5'h06));
	endtask
	task automatic t_lock;
		do_rst();
		wr(`AFRC_ADDR_MODE, 8'h08);
		`CHK(res_mode, `AFRC_RES_12BIT)
		cv(5'h05);
		rc(`AFRC_ADDR_RES_HIGH, hb(5'h05));
		cv(5'h16);
		rc(`AFRC_ADDR_RES_LOW, lb(5'h05));
		rc(`AFRC_ADDR_RES_HIGH, hb(5'h05));
		rc(`AFRC_ADDR_RES_LOW, lb(5'h05));
		cv(5'h17);
		rc(`AFRC_ADDR_RES_LOW, lb(5'h17));
		rc(`AFRC_ADDR_RES_HIGH, hb(5'h17));
		rc(`AFRC_ADDR_RES_LOW, lb(5'h17));
		cmp_en <= 1'b1;
		cv(5'h08);
		rc(`AFRC_ADDR_RES_LOW, lb(5'h17));
		cmp_en <= 1'b0;
		wr(`AFRC_ADDR_MODE, 8'h04);
		rc(`AFRC_ADDR_RES_HIGH, 8'h00);
		rc(`AFRC_ADDR_RES_LOW, 8'h00);
	endtask
	task automatic t_fifo(input logic scan);
		logic [31:0] d;
		logic [1:0]  r;
		int i;
		do_rst();
		wr(`AFRC_ADDR_FIFOCTL, {1'b0, scan, 6'h02});
		for (i = 1; i <= 3; i++) begin
			wr(`AFRC_ADDR_CHSEL, 8'(i));
			repeat (8) @(posedge sys_clk);
			if (i < 3)
				`CHK(n_start, 0)
		end
		for (i = 0; i < 60 && d[7] !== 1'b1; i++)
			rd(`AFRC_ADDR_STATUS, d, r);
		`CHK(d[7:0], 8'h84)
		`CHK(n_start, 3)
		for (i = 1; i <= 3; i++) begin
			rc(`AFRC_ADDR_RES_HIGH, hb(scan ? 5'h01 : 5'(i)));
			rc(`AFRC_ADDR_RES_LOW, lb(scan ? 5'h01 : 5'(i)));
		end
	endtask
	task automatic t_comb(input logic sel);
		logic [31:0] d;
		logic [1:0]  r;
		do_rst();
		wr(`AFRC_ADDR_FIFOCTL, {2'h0, sel, 5'h01});
		cmp_en <= 1'b1;
		wr(`AFRC_ADDR_CHSEL, 8'h01);
		wr(`AFRC_ADDR_CHSEL, 8'h02);
		repeat (30) @(posedge sys_clk);
		rd(`AFRC_ADDR_STATUS, d, r);
		`CHK(d[7], !sel)
		cmp_en <= 1'b0;
	endtask
	// scan plus continuous keeps restarting after the set completes
	task automatic t_cont;
		do_rst();
		wr(`AFRC_ADDR_MODE, 8'h10);
		wr(`AFRC_ADDR_FIFOCTL, 8'h41);
		wr(`AFRC_ADDR_CHSEL, 8'h03);
		wr(`AFRC_ADDR_CHSEL, 8'h03);
		repeat (40) @(posedge sys_clk);
		`CHK(n_start > 4, 1'b1)
	endtask
	initial begin
		{rst_b, awvalid, wvalid, bready, arvalid, rready} = 6'h0;
		{awaddr, araddr, ch_l, wdata} = 47'h0;
		{done, cmp_en, hit, result, cd} = 22'h0;
		n_fail = 0;
		check_count = 0;
		n_start = 0;
		cyc = 0;
		t_regs();
		t_nolock();
		t_lock();
		t_fifo(1'b0);
		t_fifo(1'b1);
		t_comb(1'b0);
		t_comb(1'b1);
		t_cont();
		complete_run();
	end
endmodule
`default_nettype wire
